//--- design/emu_ctrl_defines.svh
// register map, field positions, reset values and counts of the emulator reset and clock controller
`ifndef EMU_CTRL_DEFINES_SVH
`define EMU_CTRL_DEFINES_SVH

// ***************
// register offsets
// ***************
`define REG_CLKSEL 8'h00
`define REG_CMD 8'h04
`define REG_PC_VALUE 8'h08
`define REG_VECTOR 8'h0C
`define REG_BP_LO 8'h10
`define REG_BP_HI 8'h14
`define REG_STATUS 8'h18
`define REG_PC 8'h1C

// ***************
// command bits
// ***************
`define CMD_RESET 0
`define CMD_RESET_RUN 1
`define CMD_WAIT 2
`define CMD_TOGGLE_IN 3
`define CMD_TOGGLE_OUT 4
`define CMD_SET_PC 5
`define CMD_BP_CLEAR 6
`define CMD_BP_SET 7
`define CMD_ARGC_LO 8
`define CMD_ARGC_HI 9
`define ARGC_NONE 2'h0
`define ARGC_ONE 2'h1
`define ARGC_TWO 2'h2

// ***************
// status bits
// ***************
`define ST_IN_EN 0
`define ST_OUT_EN 1
`define ST_RST_BUSY 2
`define ST_BP_BUSY 3
`define ST_RUN 4
`define ST_WAIT 5
`define ST_CLK_LO 8
`define ST_CLK_HI 10

// ***************
// clocking and timing
// ***************
`define SYS_MHZ 6'h19
`define STEP_8M 6'h08
`define STEP_4M 6'h04
`define STEP_2M 6'h02
`define STEP_1M 6'h01
`define CLKSEL_RESET 3'h1
`define RESET_HOLD_TICKS 8'h10

// ***************
// breakpoint store
// ***************
`define BP_DEPTH 2048
`define BP_WORD_HI 15
`define BP_WORD_LO 5
`define BP_BIT_HI 4
`define BP_WORD_LAST 11'h7FF
`define ADDR_ALL_LO 16'h0000
`define ADDR_ALL_HI 16'hFFFF

// ***************
// bus answers
// ***************
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

//--- design/emu_ctrl_pkg.sv
// types shared by the emulator reset and clock controller
package emu_ctrl_pkg;
	typedef enum logic [2:0] {
		CLK_8M = 3'h0,
		CLK_4M = 3'h1,
		CLK_2M = 3'h2,
		CLK_1M = 3'h3,
		CLK_EXT = 3'h4
	} clk_sel_t;

	typedef enum logic [2:0] {
		RS_IDLE = 3'h1,
		RS_HOLD = 3'h2,
		RS_LOAD = 3'h4
	} rst_state_t;

	typedef enum logic [2:0] {
		BP_IDLE = 3'h1,
		BP_READ = 3'h2,
		BP_WRITE = 3'h4
	} bp_state_t;
endpackage

//--- design/bp_mem_if.sv
// signals between the controller and its breakpoint store
interface bp_mem_if;
	logic [10:0] a_addr;
	logic a_we;
	logic [31:0] a_wdata;
	logic [31:0] a_rdata;
	logic [10:0] b_addr;
	logic [31:0] b_rdata;
	modport ctrl (output a_addr, output a_we, output a_wdata, output b_addr, input a_rdata, input b_rdata);
	modport store (input a_addr, input a_we, input a_wdata, input b_addr, output a_rdata, output b_rdata);
endinterface

//--- design/bp_store.sv
// breakpoint bitmap: one bit per code address, maintenance port and lookup port, registered reads
`include "emu_ctrl_defines.svh"

module bp_store (
	input wire logic clk,
	bp_mem_if.store bus
);
	logic [31:0] mem [0:`BP_DEPTH-1];

	always_ff @(posedge clk) begin
		if (bus.a_we) begin
			mem[bus.a_addr] <= bus.a_wdata;
		end
		bus.a_rdata <= mem[bus.a_addr];
	end

	// lookup sees the old word during a write to the same word
	always_ff @(posedge clk) begin
		bus.b_rdata <= mem[bus.b_addr];
	end
endmodule

//--- design/emu_reset_clock_ctrl.sv
// emulator clock select, reset sequencing and breakpoint clearing behind an AXI4-Lite slave
//
// Summary of operation
// - internal 8, 4, 2, 1 MHz selectable
// - external clock selectable as emulator clock
// - 4 MHz selected after reset
// - reset loads vector, MCU stays halted
// - reset-and-run loads vector then runs
// - toggle command inverts target reset input enable
// - enabled: target reset resets the MCU
// - disabled: target reset is blocked
// - host enables input before wait command
// - toggle command inverts target reset output enable
// - enabled: reset also drives target board
// - disabled: target reset line left released
// - output enable applies to reset-and-run too
// - one address clears that breakpoint only
// - no address clears all breakpoints
// - two addresses clear inclusive range
// - set PC without starting execution
`include "emu_ctrl_defines.svh"

module emu_reset_clock_ctrl (
	input wire logic CLOCK,
	input wire logic RST_N,
	input wire logic [7:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [7:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire logic EXT_CLK,
	input wire logic TGT_RST_N_IN,
	output logic TGT_RST_N_OUT,
	output logic TGT_RST_OE,
	input wire logic [15:0] FETCH_ADDR,
	input wire logic FETCH_VALID,
	output logic BP_HIT,
	output logic EMU_CLK_EN,
	output logic MCU_RST_N,
	output logic MCU_RUN,
	output logic [15:0] MCU_PC,
	output logic MCU_PC_LOAD
);
	// ****************
	// functions
	// ****************
	function automatic logic is_mapped(input logic [7:0] a);
		is_mapped = (a == `REG_CLKSEL) || (a == `REG_CMD) || (a == `REG_PC_VALUE) || (a == `REG_VECTOR) ||
			(a == `REG_BP_LO) || (a == `REG_BP_HI) || (a == `REG_STATUS) || (a == `REG_PC);
	endfunction

	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
		merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction

	function automatic logic [5:0] rate_step(input emu_ctrl_pkg::clk_sel_t sel);
		unique case (sel)
			emu_ctrl_pkg::CLK_8M: rate_step = `STEP_8M;
			emu_ctrl_pkg::CLK_4M: rate_step = `STEP_4M;
			emu_ctrl_pkg::CLK_2M: rate_step = `STEP_2M;
			emu_ctrl_pkg::CLK_1M: rate_step = `STEP_1M;
			default: rate_step = 6'h00;
		endcase
	endfunction

	// rewrites one bitmap word: set mode marks lo, clear mode drops every bit in [lo, hi]
	function automatic logic [31:0] bp_modify(input logic [31:0] old, input logic [10:0] word, input logic [15:0] lo,
		input logic [15:0] hi, input logic set_mode);
		logic [15:0] a;
		a = 16'h0000;
		bp_modify = old;
		for (int i = 0; i < 32; i++) begin
			a = {word, i[4:0]};
			if (set_mode) begin
				if (a == lo) begin
					bp_modify[i] = 1'b1;
				end
			end else if (a >= lo && a <= hi) begin
				bp_modify[i] = 1'b0;
			end
		end
	endfunction

	// ****************
	// bus slave
	// ****************
	logic [7:0] aw_addr_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;
	logic wr_en;
	logic [31:0] rd_mux;

	// a write commits once both halves are held and no answer is pending
	assign wr_en = !S_AXI_AWREADY && !S_AXI_WREADY && !S_AXI_BVALID;

	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			S_AXI_AWREADY <= 1'b1;
			S_AXI_WREADY <= 1'b1;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= `RESP_OKAY;
			aw_addr_r <= 8'h00;
			w_data_r <= 32'h0000_0000;
			w_strb_r <= 4'h0;
		end else begin
			if (S_AXI_AWVALID && S_AXI_AWREADY) begin
				S_AXI_AWREADY <= 1'b0;
				aw_addr_r <= S_AXI_AWADDR;
			end
			if (S_AXI_WVALID && S_AXI_WREADY) begin
				S_AXI_WREADY <= 1'b0;
				w_data_r <= S_AXI_WDATA;
				w_strb_r <= S_AXI_WSTRB;
			end
			if (wr_en) begin
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP <= is_mapped(aw_addr_r) ? `RESP_OKAY : `RESP_SLVERR;
			end else if (S_AXI_BVALID && S_AXI_BREADY) begin
				S_AXI_BVALID <= 1'b0;
				S_AXI_AWREADY <= 1'b1;
				S_AXI_WREADY <= 1'b1;
			end
		end
	end

	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			S_AXI_ARREADY <= 1'b1;
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= 32'h0000_0000;
			S_AXI_RRESP <= `RESP_OKAY;
		end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID <= 1'b1;
			S_AXI_RDATA <= rd_mux;
			S_AXI_RRESP <= is_mapped(S_AXI_ARADDR) ? `RESP_OKAY : `RESP_SLVERR;
		end else if (S_AXI_RVALID && S_AXI_RREADY) begin
			S_AXI_RVALID <= 1'b0;
			S_AXI_ARREADY <= 1'b1;
		end
	end

	// ****************
	// control registers
	// ****************
	emu_ctrl_pkg::clk_sel_t clk_sel_r;
	logic [15:0] pc_value_r;
	logic [15:0] vector_r;
	logic [15:0] bp_lo_r;
	logic [15:0] bp_hi_r;
	logic in_en_r;
	logic out_en_r;
	logic wait_armed_r;
	logic cmd_wr;
	logic [31:0] cmd;
	logic tgt_req;
	logic rst_start;

	assign cmd_wr = wr_en && aw_addr_r == `REG_CMD && w_strb_r[0];
	assign cmd = cmd_wr ? w_data_r : 32'h0000_0000;

	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			clk_sel_r <= emu_ctrl_pkg::clk_sel_t'(`CLKSEL_RESET);
		end else if (wr_en && aw_addr_r == `REG_CLKSEL && w_strb_r[0] && w_data_r[2:0] <= 3'h4) begin
			clk_sel_r <= emu_ctrl_pkg::clk_sel_t'(w_data_r[2:0]);
		end
	end

	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			pc_value_r <= 16'h0000;
			vector_r <= 16'h0000;
			bp_lo_r <= 16'h0000;
			bp_hi_r <= 16'h0000;
		end else if (wr_en) begin
			if (aw_addr_r == `REG_PC_VALUE) pc_value_r <= merge16(pc_value_r, w_data_r, w_strb_r);
			if (aw_addr_r == `REG_VECTOR) vector_r <= merge16(vector_r, w_data_r, w_strb_r);
			if (aw_addr_r == `REG_BP_LO) bp_lo_r <= merge16(bp_lo_r, w_data_r, w_strb_r);
			if (aw_addr_r == `REG_BP_HI) bp_hi_r <= merge16(bp_hi_r, w_data_r, w_strb_r);
		end
	end

	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			in_en_r <= 1'b0;
			out_en_r <= 1'b0;
		end else begin
			if (cmd[`CMD_TOGGLE_IN]) in_en_r <= !in_en_r;
			if (cmd[`CMD_TOGGLE_OUT]) out_en_r <= !out_en_r;
		end
	end

	// the wait command only pays off once the input enable is set; arming wins over the clear
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			wait_armed_r <= 1'b0;
		end else if (cmd[`CMD_WAIT]) begin
			wait_armed_r <= 1'b1;
		end else if (rst_start && tgt_req) begin
			wait_armed_r <= 1'b0;
		end
	end

	// ****************
	// emulator clock
	// ****************
	logic [4:0] acc_r;
	logic [5:0] acc_sum;
	logic ext_q_r;
	logic tick_nxt;

	// fractional divider: exact average rate, jitter of one system cycle traded for no extra clock
	assign acc_sum = {1'b0, acc_r} + rate_step(clk_sel_r);
	always_comb begin
		if (clk_sel_r == emu_ctrl_pkg::CLK_EXT) begin
			tick_nxt = EXT_CLK && !ext_q_r;
		end else begin
			tick_nxt = acc_sum >= `SYS_MHZ;
		end
	end

	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			acc_r <= 5'h00;
			ext_q_r <= 1'b0;
			EMU_CLK_EN <= 1'b0;
		end else begin
			acc_r <= (acc_sum >= `SYS_MHZ) ? 5'(acc_sum - `SYS_MHZ) : acc_sum[4:0];
			ext_q_r <= EXT_CLK;
			EMU_CLK_EN <= tick_nxt;
		end
	end

	// ****************
	// reset sequencer
	// ****************
	emu_ctrl_pkg::rst_state_t rst_state_r;
	emu_ctrl_pkg::rst_state_t rst_state_nxt;
	logic [7:0] rst_cnt_r;
	logic [7:0] rst_cnt_nxt;
	logic to_tgt_r;
	logic to_tgt_nxt;
	logic run_after_r;
	logic run_after_nxt;

	assign tgt_req = in_en_r && !TGT_RST_N_IN;
	assign rst_start = rst_state_r == emu_ctrl_pkg::RS_IDLE &&
		(tgt_req || cmd[`CMD_RESET] || cmd[`CMD_RESET_RUN]);

	always_comb begin
		rst_state_nxt = rst_state_r;
		rst_cnt_nxt = rst_cnt_r;
		to_tgt_nxt = to_tgt_r;
		run_after_nxt = run_after_r;
		unique case (rst_state_r)
			emu_ctrl_pkg::RS_IDLE: begin
				rst_cnt_nxt = 8'h00;
				if (tgt_req) begin
					rst_state_nxt = emu_ctrl_pkg::RS_HOLD;
					to_tgt_nxt = 1'b0;
					run_after_nxt = wait_armed_r;
				end else if (cmd[`CMD_RESET] || cmd[`CMD_RESET_RUN]) begin
					rst_state_nxt = emu_ctrl_pkg::RS_HOLD;
					to_tgt_nxt = out_en_r;
					run_after_nxt = cmd[`CMD_RESET_RUN];
				end
			end
			emu_ctrl_pkg::RS_HOLD: begin
				// a held target reset keeps restarting the count, so release follows the target
				if (tgt_req && !to_tgt_r) begin
					rst_cnt_nxt = 8'h00;
				end else if (EMU_CLK_EN) begin
					if (rst_cnt_r == `RESET_HOLD_TICKS - 8'h01) begin
						rst_state_nxt = emu_ctrl_pkg::RS_LOAD;
					end else begin
						rst_cnt_nxt = rst_cnt_r + 8'h01;
					end
				end
			end
			emu_ctrl_pkg::RS_LOAD: begin
				rst_state_nxt = emu_ctrl_pkg::RS_IDLE;
			end
			default: rst_state_nxt = emu_ctrl_pkg::RS_IDLE;
		endcase
	end

	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			rst_state_r <= emu_ctrl_pkg::RS_IDLE;
			rst_cnt_r <= 8'h00;
			to_tgt_r <= 1'b0;
			run_after_r <= 1'b0;
			MCU_RST_N <= 1'b1;
			TGT_RST_OE <= 1'b0;
			TGT_RST_N_OUT <= 1'b0;
		end else begin
			rst_state_r <= rst_state_nxt;
			rst_cnt_r <= rst_cnt_nxt;
			to_tgt_r <= to_tgt_nxt;
			run_after_r <= run_after_nxt;
			MCU_RST_N <= rst_state_nxt != emu_ctrl_pkg::RS_HOLD;
			TGT_RST_OE <= rst_state_nxt == emu_ctrl_pkg::RS_HOLD && to_tgt_nxt;
			TGT_RST_N_OUT <= 1'b0;
		end
	end

	// program counter and run state; set-PC is ignored while a reset is in progress
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			MCU_PC <= 16'h0000;
			MCU_PC_LOAD <= 1'b0;
			MCU_RUN <= 1'b0;
		end else begin
			MCU_PC_LOAD <= 1'b0;
			if (rst_start) begin
				MCU_RUN <= 1'b0;
			end else if (rst_state_r == emu_ctrl_pkg::RS_LOAD) begin
				MCU_PC <= vector_r;
				MCU_PC_LOAD <= 1'b1;
				MCU_RUN <= run_after_r;
			end else if (cmd[`CMD_SET_PC] && rst_state_r == emu_ctrl_pkg::RS_IDLE) begin
				MCU_PC <= pc_value_r;
				MCU_PC_LOAD <= 1'b1;
			end
		end
	end

	// ****************
	// breakpoint maintenance
	// ****************
	bp_mem_if bpm ();
	emu_ctrl_pkg::bp_state_t bp_state_r;
	logic [10:0] bp_word_r;
	logic [10:0] bp_last_r;
	logic [15:0] op_lo_r;
	logic [15:0] op_hi_r;
	logic op_set_r;
	logic [15:0] req_lo;
	logic [15:0] req_hi;
	logic req_ok;
	logic [4:0] fetch_bit_r;
	logic fetch_valid_r;

	always_comb begin
		req_lo = bp_lo_r;
		req_hi = bp_lo_r;
		req_ok = cmd[`CMD_BP_SET];
		if (cmd[`CMD_BP_CLEAR]) begin
			req_ok = 1'b1;
			unique case (cmd[`CMD_ARGC_HI:`CMD_ARGC_LO])
				`ARGC_NONE: begin
					req_lo = `ADDR_ALL_LO;
					req_hi = `ADDR_ALL_HI;
				end
				`ARGC_ONE: req_hi = bp_lo_r;
				`ARGC_TWO: req_hi = bp_hi_r;
				default: req_ok = 1'b0;
			endcase
		end
		if (req_lo > req_hi) begin
			req_ok = 1'b0;
		end
	end

	// after reset the bitmap is swept clear; lookups are not held off while the sweep runs
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			bp_state_r <= emu_ctrl_pkg::BP_READ;
			bp_word_r <= 11'h000;
			bp_last_r <= `BP_WORD_LAST;
			op_lo_r <= `ADDR_ALL_LO;
			op_hi_r <= `ADDR_ALL_HI;
			op_set_r <= 1'b0;
		end else begin
			unique case (bp_state_r)
				emu_ctrl_pkg::BP_IDLE: begin
					if (req_ok) begin
						bp_state_r <= emu_ctrl_pkg::BP_READ;
						bp_word_r <= req_lo[`BP_WORD_HI:`BP_WORD_LO];
						bp_last_r <= req_hi[`BP_WORD_HI:`BP_WORD_LO];
						op_lo_r <= req_lo;
						op_hi_r <= req_hi;
						op_set_r <= !cmd[`CMD_BP_CLEAR];
					end
				end
				emu_ctrl_pkg::BP_READ: bp_state_r <= emu_ctrl_pkg::BP_WRITE;
				emu_ctrl_pkg::BP_WRITE: begin
					if (bp_word_r == bp_last_r) begin
						bp_state_r <= emu_ctrl_pkg::BP_IDLE;
					end else begin
						bp_word_r <= bp_word_r + 11'h001;
						bp_state_r <= emu_ctrl_pkg::BP_READ;
					end
				end
				default: bp_state_r <= emu_ctrl_pkg::BP_IDLE;
			endcase
		end
	end

	assign bpm.a_addr = bp_word_r;
	assign bpm.a_we = bp_state_r == emu_ctrl_pkg::BP_WRITE;
	assign bpm.a_wdata = bp_modify(bpm.a_rdata, bp_word_r, op_lo_r, op_hi_r, op_set_r);
	assign bpm.b_addr = FETCH_ADDR[`BP_WORD_HI:`BP_WORD_LO];

	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			fetch_bit_r <= 5'h00;
			fetch_valid_r <= 1'b0;
			BP_HIT <= 1'b0;
		end else begin
			fetch_bit_r <= FETCH_ADDR[`BP_BIT_HI:0];
			fetch_valid_r <= FETCH_VALID;
			BP_HIT <= fetch_valid_r && bpm.b_rdata[fetch_bit_r];
		end
	end

	bp_store u_store (
		.clk(CLOCK),
		.bus(bpm.store)
	);

	// ****************
	// read multiplexer
	// ****************
	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (S_AXI_ARADDR)
			`REG_CLKSEL: rd_mux[2:0] = clk_sel_r;
			`REG_PC_VALUE: rd_mux[15:0] = pc_value_r;
			`REG_VECTOR: rd_mux[15:0] = vector_r;
			`REG_BP_LO: rd_mux[15:0] = bp_lo_r;
			`REG_BP_HI: rd_mux[15:0] = bp_hi_r;
			`REG_PC: rd_mux[15:0] = MCU_PC;
			`REG_STATUS: begin
				rd_mux[`ST_IN_EN] = in_en_r;
				rd_mux[`ST_OUT_EN] = out_en_r;
				rd_mux[`ST_RST_BUSY] = rst_state_r != emu_ctrl_pkg::RS_IDLE;
				rd_mux[`ST_BP_BUSY] = bp_state_r != emu_ctrl_pkg::BP_IDLE;
				rd_mux[`ST_RUN] = MCU_RUN;
				rd_mux[`ST_WAIT] = wait_armed_r;
				rd_mux[`ST_CLK_HI:`ST_CLK_LO] = clk_sel_r;
			end
			default: rd_mux = 32'h0000_0000;
		endcase
	end
endmodule

//--- test/emu_reset_clock_ctrl_properties.sv
// port assertions for the emulator reset and clock controller
module emu_ctrl_checker (
	input wire logic CLOCK,
	input wire logic RST_N,
	input wire logic EMU_CLK_EN,
	input wire logic MCU_RST_N,
	input wire logic MCU_RUN,
	input wire logic MCU_PC_LOAD,
	input wire logic TGT_RST_OE,
	input wire logic TGT_RST_N_OUT
);
	// ***************
	// ticks seen while the mcu is held
	// ***************
	logic [7:0] ticks_r;
	// saturates so a long target hold cannot wrap below the minimum
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N)
			ticks_r <= 8'h00;
		else if (MCU_RST_N)
			ticks_r <= 8'h00;
		else if (EMU_CLK_EN && ticks_r != 8'hFF)
			ticks_r <= ticks_r + 8'h01;
	end

	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (!RST_N);

	sequence s_enter;
		$fell(MCU_RST_N);
	endsequence
	sequence s_release;
		$rose(MCU_RST_N);
	endsequence

	a_hold_min_ticks: assert property (s_release |-> ticks_r >= 8'h10)
		else $error("mcu reset released before minimum ticks");
	a_hold_low_span: assert property (s_enter |-> !MCU_RST_N [*8])
		else $error("mcu reset pulse too short");
	a_load_after_hold: assert property (s_release |=> MCU_PC_LOAD)
		else $error("no pc load after reset release");
	a_halt_in_reset: assert property (!MCU_RST_N |-> !MCU_RUN)
		else $error("mcu running while held in reset");
	a_drive_only_held: assert property (TGT_RST_OE |-> !MCU_RST_N)
		else $error("target reset driven outside mcu reset");
	a_drive_level_low: assert property (TGT_RST_N_OUT == 1'b0)
		else $error("target reset data not low");
	a_tick_spacing: assert property (EMU_CLK_EN |=> !EMU_CLK_EN)
		else $error("emulator ticks too close");
	a_pc_pulse_single: assert property (MCU_PC_LOAD |=> !MCU_PC_LOAD)
		else $error("pc load pulse longer than one cycle");
endmodule

bind emu_reset_clock_ctrl emu_ctrl_checker u_emu_ctrl_checker(.CLOCK(CLOCK), .RST_N(RST_N),
	.EMU_CLK_EN(EMU_CLK_EN), .MCU_RST_N(MCU_RST_N), .MCU_RUN(MCU_RUN), .MCU_PC_LOAD(MCU_PC_LOAD),
	.TGT_RST_OE(TGT_RST_OE), .TGT_RST_N_OUT(TGT_RST_N_OUT));

//--- test/target_board_model.sv
// target board: open-drain reset line with pull-up and a free running external clock
module target_board_model (
	input wire logic clk,
	input wire logic drive_oe,
	input wire logic drive_val,
	input wire logic hold_low,
	input wire logic seen_clr,
	output logic line_n,
	output logic ext_clk,
	output logic board_seen
);
	timeunit 1ns;
	timeprecision 1ns;
	// pulled up, so released means high, never the last driven value
	assign line_n = !((drive_oe && !drive_val) || hold_low);
	// period 120 ns, phase unrelated to the system clock
	initial begin
		ext_clk = 1'b0;
		#17;
		forever #60 ext_clk = !ext_clk;
	end
	always @(posedge clk) begin
		if (seen_clr)
			board_seen <= 1'b0;
		else if (drive_oe && !drive_val)
			board_seen <= 1'b1;
	end
endmodule

//--- test/emu_reset_clock_ctrl_bench.sv
// self-checking bench for the emulator reset and clock controller
`include "emu_ctrl_defines.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
	$display("unexpected at %0t: got %0h expected %0h", $time, (g), (e)); end end

module emu_reset_clock_ctrl_bench;
	timeunit 1ns;
	timeprecision 1ns;
	int n_mismatch = 0;
	int n_checks = 0;
	int cnt;
	int n_load = 0;
	int loads_done = 0;
	logic CLOCK = 1'b0, RST_N = 1'b0, hold_low = 1'b0, seen_clr = 1'b1, FETCH_VALID = 1'b0;
	logic S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0, S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0;
	logic [7:0] S_AXI_AWADDR = 8'h00, S_AXI_ARADDR = 8'h00;
	logic [31:0] S_AXI_WDATA = 32'h0, S_AXI_RDATA, rd;
	logic [3:0] S_AXI_WSTRB = 4'hF;
	logic [15:0] FETCH_ADDR = 16'h0, MCU_PC, vec, a;
	logic [1:0] S_AXI_BRESP, S_AXI_RRESP, resp;
	logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID, EXT_CLK, TGT_RST_N_IN;
	logic TGT_RST_N_OUT, TGT_RST_OE, BP_HIT, EMU_CLK_EN, MCU_RST_N, MCU_RUN, MCU_PC_LOAD, board_seen;
	logic [15:0] offs [5] = '{16'hFFFF, 16'h0000, 16'h0005, 16'h0006, 16'h0028};
	logic [4:0] mask [4] = '{5'h1F, 5'h0F, 5'h09, 5'h00};

	emu_reset_clock_ctrl u_emu_reset_clock_ctrl(.CLOCK(CLOCK), .RST_N(RST_N),
		.S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
		.S_AXI_WDATA(S_AXI_WDATA), .S_AXI_WSTRB(S_AXI_WSTRB), .S_AXI_WVALID(S_AXI_WVALID),
		.S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID),
		.S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID),
		.S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP),
		.S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY), .EXT_CLK(EXT_CLK),
		.TGT_RST_N_IN(TGT_RST_N_IN), .TGT_RST_N_OUT(TGT_RST_N_OUT), .TGT_RST_OE(TGT_RST_OE),
		.FETCH_ADDR(FETCH_ADDR), .FETCH_VALID(FETCH_VALID), .BP_HIT(BP_HIT), .EMU_CLK_EN(EMU_CLK_EN),
		.MCU_RST_N(MCU_RST_N), .MCU_RUN(MCU_RUN), .MCU_PC(MCU_PC), .MCU_PC_LOAD(MCU_PC_LOAD));
	target_board_model u_target_board_model(.clk(CLOCK), .drive_oe(TGT_RST_OE), .drive_val(TGT_RST_N_OUT),
		.hold_low(hold_low), .seen_clr(seen_clr), .line_n(TGT_RST_N_IN), .ext_clk(EXT_CLK), .board_seen(board_seen));

	always #20 CLOCK = !CLOCK;

	// load pulses are counted, so a one-cycle pulse that falls inside a bus task is not missed
	always @(posedge CLOCK) begin
		if (MCU_PC_LOAD === 1'b1) begin
			n_load <= n_load + 1;
		end
	end

	// ***************
	// bus, port and closing tasks
	// ***************
	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		int n = 0;
		S_AXI_AWADDR <= ad;
		S_AXI_WDATA <= d;
		S_AXI_AWVALID <= 1'b1;
		S_AXI_WVALID <= 1'b1;
		S_AXI_BREADY <= 1'b1;
		do begin
			@(posedge CLOCK);
			n++;
			if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
			if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
		end while (!S_AXI_BVALID && n < 200);
		// ready stays up between writes, so back-to-back calls never drive it twice in one step
		`CHK(S_AXI_BVALID, 1'b1)
		resp = S_AXI_BRESP;
	endtask
	task automatic rdr(input logic [7:0] ad);
		int n = 0;
		S_AXI_ARADDR <= ad;
		S_AXI_ARVALID <= 1'b1;
		S_AXI_RREADY <= 1'b1;
		do begin
			@(posedge CLOCK);
			n++;
			if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
		end while (!S_AXI_RVALID && n < 200);
		`CHK(S_AXI_RVALID, 1'b1)
		rd = S_AXI_RDATA;
		resp = S_AXI_RRESP;
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge CLOCK);
	endtask
	task automatic wait_load();
		int n = 0;
		do begin
			@(posedge CLOCK);
			n++;
		end while (n_load == loads_done && n < 3000);
		`CHK(n_load != loads_done, 1'b1)
		loads_done = n_load;
	endtask
	task automatic bp_wait();
		int n = 0;
		do begin
			rdr(`REG_STATUS);
			n++;
		end while (rd[`ST_BP_BUSY] !== 1'b0 && n < 3000);
		`CHK(rd[`ST_BP_BUSY], 1'b0)
	endtask
	task automatic bpcmd(input logic [15:0] lo, input logic [15:0] hi, input logic [31:0] c);
		wr(`REG_BP_LO, {16'h0, lo});
		wr(`REG_BP_HI, {16'h0, hi});
		wr(`REG_CMD, c);
		bp_wait();
	endtask
	// hit is sampled two cycles after the fetch cycle
	task automatic look(input logic [15:0] ad, input logic e);
		FETCH_ADDR <= ad;
		FETCH_VALID <= 1'b1;
		@(posedge CLOCK);
		FETCH_VALID <= 1'b0;
		cyc(2);
		`CHK(BP_HIT, e)
	endtask
	task automatic pull();
		cnt = 0;
		hold_low <= 1'b1;
		repeat (20) begin
			@(posedge CLOCK);
			cnt += !MCU_RST_N;
		end
		hold_low <= 1'b0;
	endtask
	function automatic int exp_ticks(input int s, input int n);
		return (s == 4) ? n / 3 : n * (8 >> s) / 25;
	endfunction
	task automatic conclude();
		if (n_mismatch == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// about 10000 cycles are expected, the limit leaves wide margin
	initial begin
		#1600000;
		n_mismatch++;
		conclude();
	end

	// ***************
	// main sequence
	// ***************
	initial begin
		void'($urandom(32'h3E43C69D));
		repeat (8) @(posedge CLOCK);
		RST_N <= 1'b1;
		seen_clr <= 1'b0;
		@(posedge CLOCK);
		rdr(`REG_STATUS);
		`CHK(rd[10:8], 3'h1)
		bp_wait();
		for (int s = 4; s >= 0; s--) begin
			wr(`REG_CLKSEL, 32'(s));
			cyc(10);
			cnt = 0;
			repeat (300) begin
				@(posedge CLOCK);
				cnt += EMU_CLK_EN;
			end
			`CHK(cnt >= exp_ticks(s, 300) - 1 && cnt <= exp_ticks(s, 300) + 1, 1'b1)
		end
		for (int i = 0; i < 4; i++) begin
			if (i == 2) wr(`REG_CMD, 32'h10);
			vec = 16'($urandom);
			wr(`REG_VECTOR, {16'h0, vec});
			seen_clr <= 1'b1;
			cyc(1);
			seen_clr <= 1'b0;
			wr(`REG_CMD, i[0] ? 32'h2 : 32'h1);
			wait_load();
			`CHK(MCU_PC, vec)
			`CHK(MCU_RUN, i[0])
			`CHK(board_seen, i[1])
			rdr(`REG_STATUS);
			`CHK(rd[1], i[1])
		end
		pull();
		`CHK(cnt, 0)
		`CHK(MCU_RUN, 1'b1)
		wr(`REG_CMD, 32'h8);
		rdr(`REG_STATUS);
		`CHK(rd[0], 1'b1)
		pull();
		`CHK(cnt, 19)
		wait_load();
		`CHK(MCU_PC, vec)
		`CHK(MCU_RUN, 1'b0)
		a = 16'($urandom);
		wr(`REG_PC_VALUE, {16'h0, a});
		wr(`REG_CMD, 32'h20);
		wait_load();
		`CHK(MCU_PC, a)
		`CHK(MCU_RUN, 1'b0)
		wr(`REG_CMD, 32'h4);
		pull();
		wait_load();
		`CHK(MCU_RUN, 1'b1)
		wr(`REG_CMD, 32'h8);
		rdr(`REG_STATUS);
		`CHK(rd[0], 1'b0)
		a = 16'h0100 + 16'($urandom % 32'h7000);
		for (int k = 0; k < 5; k++)
			bpcmd(a + offs[k], a + offs[k], 32'h80);
		for (int st = 0; st < 4; st++) begin
			if (st == 1) bpcmd(a + 16'h0028, a + 16'h0028, 32'h140);
			if (st == 2) bpcmd(a, a + 16'h0005, 32'h240);
			if (st == 3) bpcmd(16'h0000, 16'hFFFF, 32'h40);
			for (int k = 0; k < 5; k++)
				look(a + offs[k], mask[st][k]);
		end
		wr(8'h40, 32'h0);
		`CHK(resp, `RESP_SLVERR)
		rdr(8'h40);
		`CHK(resp, `RESP_SLVERR)
		`CHK(rd, 32'h0)
		conclude();
	end
endmodule
